/* hdl/crf_pkg.sv */
// Constants, enumerations and carrier structs for the CPU core register file.
// Assumes one clock domain and a sequencer that drives one command per step.
package crf_pkg;

    // ****************************************************************
    // Reset values and fixed address fields
    // ****************************************************************
    localparam logic [15:0] SP_RESET = 16'h00FF;       // Stack pointer after reset
    localparam logic [7:0] IDX_HI_RESET = 8'h00;       // High index byte after reset
    localparam logic [7:0] SP_LOW_RESET = 8'hFF;       // Low stack byte after low reset
    localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;     // Direct page is 0x0000-0x00FF
    localparam logic [15:0] SP_STEP = 16'h0001;        // One byte per push or pull

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    // Operations on an 8-bit data register
    typedef enum logic [3:0] {
        UOP_CLR, UOP_INC, UOP_DEC, UOP_COM, UOP_NEG,
        UOP_LSL, UOP_LSR, UOP_ASR, UOP_ROL, UOP_ROR
    } crf_uop_t;

    // Stack pointer operations
    typedef enum logic [2:0] {
        SPOP_NONE, SPOP_LOAD, SPOP_ADJUST, SPOP_LOW_RESET, SPOP_PUSH, SPOP_PULL
    } crf_spop_t;

    // Effective address modes
    typedef enum logic [2:0] {
        AM_NONE, AM_DIRECT, AM_EXTENDED, AM_IDX_HX, AM_IDX_X, AM_IDX_SP, AM_RELATIVE
    } crf_amode_t;

    // Automatic stacking requests
    typedef enum logic [1:0] {
        STK_NONE, STK_CALL, STK_IRQ
    } crf_stk_t;

    // ****************************************************************
    // Carrier structs
    // ****************************************************************
    typedef struct packed {
        logic acc_we;
        logic [7:0] acc_wdata;
        logic x_we;
        logic [7:0] x_wdata;
        logic h_we;
        logic [7:0] h_wdata;
        logic x_op_en;
        crf_uop_t x_op;
        logic carry_in;
        crf_spop_t sp_op;
        logic [15:0] sp_wdata;
        logic [7:0] sp_imm;
        crf_amode_t amode;
        logic [15:0] addr_ofs;
        logic [15:0] pc;
        crf_stk_t stk;
        logic [7:0] ccr;
    } crf_cmd_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } crf_mem_t;

endpackage

/* hdl/crf_regfile.sv */
// CPU core register file: accumulator, index pair, stack pointer,
// effective address forming and automatic stacking of return state.
// Assumes the instruction sequencer drives one command per enabled clock
// and holds off new commands while o_busy is high.
//
// Contract
// - 8-bit accumulator feeds ALU, takes results
// - Reset leaves accumulator unchanged
// - Index pair is two 8-bit registers
// - Indexed uses full pair; legacy uses low
// - Low index works as data register
// - Reset clears high index, keeps low
// - 16-bit stack pointer to next free
// - Reset loads stack pointer 0x00FF
// - Stack adjust adds signed 8-bit immediate
// - Stack low reset touches only low byte
// - Calls and interrupts stack return state
// - Registers have no memory address
// - Direct addressing limited to page zero
// - Branch target is PC plus signed offset
`timescale 1ns/10ps

module crf_regfile (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    input wire crf_pkg::crf_cmd_t i_cmd,
    output logic [7:0] o_acc,
    output logic [7:0] o_idx_hi,
    output logic [7:0] o_idx_lo,
    output logic [15:0] o_stack_pointer,
    output logic o_x_carry,
    output logic [15:0] o_ea,
    output logic o_ea_valid,
    output crf_pkg::crf_mem_t o_mem,
    output logic o_busy
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_PCL, ST_PCH, ST_XR, ST_AR, ST_CCR
    } crf_stk_state_t;

    // Architectural registers, stacking state and return snapshot
    crf_stk_state_t stk_state_r;
    crf_stk_state_t stk_state_nxt;
    logic [7:0] acc_r;
    logic [7:0] idx_hi_r;
    logic [7:0] idx_lo_r;
    logic [15:0] sp_r;
    logic [15:0] sp_nxt;
    logic [15:0] snap_pc_r;
    logic [7:0] snap_ccr_r;
    logic snap_irq_r;
    logic [7:0] uop_result;
    logic uop_carry;
    logic cmd_take;
    logic stacking;
    logic stk_req;

    // Sign extension of an 8-bit two's complement value to 16 bits
    // Shared by the stack adjust and by relative branch forming
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    // Commands are taken only when enabled and no stacking is running
    // Refusing them meanwhile keeps the stacked X and A values stable
    assign cmd_take = i_ce & i_cmd_valid & (stk_state_r == ST_IDLE);
    assign stacking = (stk_state_r != ST_IDLE);

    // One decode of a stacking request, shared by sequencer and snapshot
    assign stk_req = cmd_take & (i_cmd.stk != crf_pkg::STK_NONE);

    // ****************************************************************
    // Low index data unit
    // ****************************************************************
    // The result is used only when x_op_en selects it
    // low index operations
    crf_unary_alu u_x_alu (
        .i_data(idx_lo_r),
        .i_op(i_cmd.x_op),
        .i_carry(i_cmd.carry_in),
        .o_result(uop_result),
        .o_carry(uop_carry)
    );

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    // no reset term here
    // Left out of reset on purpose: software must load it before use
    always_ff @(posedge i_clk) begin
        if (cmd_take && i_cmd.acc_we) begin
            acc_r <= i_cmd.acc_wdata;
        end
    end

    // ****************************************************************
    // Index pair
    // ****************************************************************
    // high byte cleared on reset
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            idx_hi_r <= crf_pkg::IDX_HI_RESET;
        end else if (cmd_take && i_cmd.h_we) begin
            idx_hi_r <= i_cmd.h_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (cmd_take && i_cmd.x_op_en) begin
            idx_lo_r <= uop_result;
        end else if (cmd_take && i_cmd.x_we) begin
            idx_lo_r <= i_cmd.x_wdata;
        end
    end

    // Carry from the last low index operation
    // Plain writes keep it, so a rotate can follow a shift
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_x_carry <= 1'b0;
        end else if (cmd_take && i_cmd.x_op_en) begin
            o_x_carry <= uop_carry;
        end
    end

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    // Next value; stacking owns the pointer while it runs
    // Commands are refused while stacking, so the two never compete
    always_comb begin
        sp_nxt = sp_r;
        if (stacking) begin
            sp_nxt = sp_r - crf_pkg::SP_STEP;
        end else if (cmd_take) begin
            case (i_cmd.sp_op)
                crf_pkg::SPOP_LOAD: sp_nxt = i_cmd.sp_wdata;
                crf_pkg::SPOP_ADJUST: sp_nxt = sp_r + sext8(i_cmd.sp_imm);
                crf_pkg::SPOP_LOW_RESET: sp_nxt = {sp_r[15:8], crf_pkg::SP_LOW_RESET};
                crf_pkg::SPOP_PUSH: sp_nxt = sp_r - crf_pkg::SP_STEP;
                crf_pkg::SPOP_PULL: sp_nxt = sp_r + crf_pkg::SP_STEP;
                default: sp_nxt = sp_r;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sp_r <= crf_pkg::SP_RESET;
        end else if (i_ce) begin
            sp_r <= sp_nxt;
        end
    end

    // ****************************************************************
    // Automatic stacking sequencer
    // ****************************************************************
    // Call pushes two bytes; interrupt entry pushes five
    // Order is return low, return high, then X, A and flags
    always_comb begin
        stk_state_nxt = stk_state_r;
        case (stk_state_r)
            ST_IDLE: begin
                if (stk_req) begin
                    stk_state_nxt = ST_PCL;
                end
            end
            ST_PCL: stk_state_nxt = ST_PCH;
            ST_PCH: stk_state_nxt = snap_irq_r ? ST_XR : ST_IDLE;
            ST_XR: stk_state_nxt = ST_AR;
            ST_AR: stk_state_nxt = ST_CCR;
            ST_CCR: stk_state_nxt = ST_IDLE;
            default: stk_state_nxt = ST_IDLE;
        endcase
    end

    // Frozen like the rest of the state while the enable is low
    // stacking state machine
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            stk_state_r <= ST_IDLE;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            stk_state_r <= stk_state_nxt;
            o_busy <= (stk_state_nxt != ST_IDLE);
        end
    end

    // Snapshot of return address and flags at the request
    // Held through the sequence because the command bus may change
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            snap_pc_r <= 16'h0000;
            snap_ccr_r <= 8'h00;
            snap_irq_r <= 1'b0;
        end else if (stk_req) begin
            snap_pc_r <= i_cmd.pc;
            snap_ccr_r <= i_cmd.ccr;
            snap_irq_r <= (i_cmd.stk == crf_pkg::STK_IRQ);
        end
    end

    // ****************************************************************
    // Memory port for stack traffic
    // ****************************************************************
    // Write lands at the current pointer, then the pointer moves down
    // Clearing each enabled cycle drops we and re after the last transfer; stacking holds we for 2 or 5 cycles
    // Pull reads at the incremented pointer, the byte pushed last
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_mem <= '0;
        end else if (i_ce) begin
            o_mem <= '0;
            case (stk_state_r)
                ST_PCL: o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: snap_pc_r[7:0]};
                ST_PCH: o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: snap_pc_r[15:8]};
                ST_XR: o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: idx_lo_r};
                ST_AR: o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: acc_r};
                ST_CCR: o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: snap_ccr_r};
                default: begin
                    if (cmd_take && i_cmd.sp_op == crf_pkg::SPOP_PUSH) begin
                        o_mem <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: i_cmd.sp_wdata[7:0]};
                    end else if (cmd_take && i_cmd.sp_op == crf_pkg::SPOP_PULL) begin
                        o_mem <= '{we: 1'b0, re: 1'b1, addr: sp_nxt, wdata: 8'h00};
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Effective address forming
    // ****************************************************************
    // Uses register values before this step's update
    // Offset sums wrap at 16 bits, inside the one address space
    // An idle cycle lowers the strobe but keeps the last address
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_ea <= 16'h0000;
            o_ea_valid <= 1'b0;
        end else if (i_ce) begin
            o_ea_valid <= cmd_take && (i_cmd.amode != crf_pkg::AM_NONE);
            if (cmd_take) begin
                case (i_cmd.amode)
                    crf_pkg::AM_DIRECT: o_ea <= {crf_pkg::DIRECT_PAGE_HI, i_cmd.addr_ofs[7:0]};
                    crf_pkg::AM_EXTENDED: o_ea <= i_cmd.addr_ofs;
                    crf_pkg::AM_IDX_HX: o_ea <= {idx_hi_r, idx_lo_r} + i_cmd.addr_ofs;
                    crf_pkg::AM_IDX_X: o_ea <= {8'h00, idx_lo_r} + i_cmd.addr_ofs;
                    crf_pkg::AM_IDX_SP: o_ea <= sp_r + i_cmd.addr_ofs;
                    crf_pkg::AM_RELATIVE: o_ea <= i_cmd.pc + sext8(i_cmd.addr_ofs[7:0]);
                    default: o_ea <= o_ea;
                endcase
            end
        end
    end

    // ****************************************************************
    // Register outputs
    // ****************************************************************
    // visible only on ports
    // No address decode exists, so no load or store can reach them
    // The mirrors cost one cycle of latency but keep outputs on flops
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_acc <= acc_r;
            o_idx_lo <= idx_lo_r;
        end
    end

    // Pointer and high byte mirrors carry reset values
    // so the pins show them while reset is still held
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_idx_hi <= crf_pkg::IDX_HI_RESET;
            o_stack_pointer <= crf_pkg::SP_RESET;
        end else if (i_ce) begin
            o_idx_hi <= idx_hi_r;
            o_stack_pointer <= sp_r;
        end
    end

endmodule

/* hdl/crf_unary_alu.sv */
// Combinational 8-bit unary operation unit for the low index register.
// Assumes the caller registers the result; no state lives here.
`timescale 1ns/10ps

module crf_unary_alu (
    input wire logic [7:0] i_data,
    input wire crf_pkg::crf_uop_t i_op,
    input wire logic i_carry,
    output logic [7:0] o_result,
    output logic o_carry
);

    // ****************************************************************
    // Operation select
    // ****************************************************************
    // Shift and rotate carry out follows the bit that falls off
    always_comb begin
        o_result = i_data;
        o_carry = i_carry;
        case (i_op)
            crf_pkg::UOP_CLR: begin
                o_result = 8'h00;
                o_carry = 1'b0;
            end
            crf_pkg::UOP_INC: o_result = i_data + 8'h01;
            crf_pkg::UOP_DEC: o_result = i_data - 8'h01;
            crf_pkg::UOP_COM: begin
                o_result = ~i_data;
                o_carry = 1'b1;
            end
            crf_pkg::UOP_NEG: begin
                o_result = 8'h00 - i_data;
                o_carry = (i_data != 8'h00);
            end
            crf_pkg::UOP_LSL: begin
                o_result = {i_data[6:0], 1'b0};
                o_carry = i_data[7];
            end
            crf_pkg::UOP_LSR: begin
                o_result = {1'b0, i_data[7:1]};
                o_carry = i_data[0];
            end
            crf_pkg::UOP_ASR: begin
                o_result = {i_data[7], i_data[7:1]};
                o_carry = i_data[0];
            end
            crf_pkg::UOP_ROL: begin
                o_result = {i_data[6:0], i_carry};
                o_carry = i_data[7];
            end
            crf_pkg::UOP_ROR: begin
                o_result = {i_carry, i_data[7:1]};
                o_carry = i_data[0];
            end
            default: begin
                o_result = i_data;
                o_carry = i_carry;
            end
        endcase
    end

endmodule

/* verification/crf_regfile_sva.sv */
// Port checker for the CPU core register file.
// Assumes one clock domain and the command contract of the design.
`timescale 1ns/10ps
module crf_regfile_sva (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    input wire crf_pkg::crf_cmd_t i_cmd,
    input wire logic [7:0] o_acc,
    input wire logic [7:0] o_idx_hi,
    input wire logic [7:0] o_idx_lo,
    input wire logic [15:0] o_stack_pointer,
    input wire logic o_x_carry,
    input wire logic [15:0] o_ea,
    input wire logic o_ea_valid,
    input wire crf_pkg::crf_mem_t o_mem,
    input wire logic o_busy
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // A command counts only when enabled and not stacking
    wire logic taken = i_ce && i_cmd_valid && !o_busy;
    reset_vals_a: assert property ($rose(i_nrst) |->
        o_stack_pointer == 16'h00FF && o_idx_hi == 8'h00 && !o_busy) else $error("reset values wrong");
    ea_direct_a: assert property (taken && i_cmd.amode == crf_pkg::AM_DIRECT |=>
        o_ea_valid && o_ea == {8'h00, $past(i_cmd.addr_ofs[7:0])}) else $error("direct address wrong");
    ea_rel_a: assert property (taken && i_cmd.amode == crf_pkg::AM_RELATIVE |=>
        o_ea == $past(i_cmd.pc) + {{8{$past(i_cmd.addr_ofs[7])}}, $past(i_cmd.addr_ofs[7:0])})
        else $error("relative address wrong");
    ea_pulse_a: assert property (o_ea_valid && i_ce && !(taken && i_cmd.amode != crf_pkg::AM_NONE)
        |=> !o_ea_valid) else $error("address strobe too long");
    sp_adjust_a: assert property (taken && i_cmd.sp_op == crf_pkg::SPOP_ADJUST
        && i_cmd.stk == crf_pkg::STK_NONE ##1 i_ce |=> o_stack_pointer == $past(o_stack_pointer)
        + {{8{$past(i_cmd.sp_imm[7], 2)}}, $past(i_cmd.sp_imm, 2)}) else $error("stack adjust wrong");
    sp_low_a: assert property (taken && i_cmd.sp_op == crf_pkg::SPOP_LOW_RESET
        && i_cmd.stk == crf_pkg::STK_NONE ##1 i_ce |=> o_stack_pointer == {$past(o_stack_pointer[15:8]), 8'hFF})
        else $error("stack low reset wrong");
    call_pcl_a: assert property (taken && i_cmd.stk == crf_pkg::STK_CALL ##1 i_ce |=> o_mem.we
        && o_mem.wdata == $past(i_cmd.pc[7:0], 2) && o_mem.addr == $past(o_stack_pointer))
        else $error("call push wrong");
    irq_ccr_a: assert property (taken && i_cmd.stk == crf_pkg::STK_IRQ ##1 i_ce [*5] |=>
        o_mem.we && o_mem.wdata == $past(i_cmd.ccr, 6) && !o_busy) else $error("interrupt frame wrong");
    mem_cause_a: assert property (o_mem.we && $past(i_ce) |-> $past(o_busy)
        || $past(taken && i_cmd.sp_op == crf_pkg::SPOP_PUSH)) else $error("memory write outside stacking or push");
    ce_freeze_a: assert property (!i_ce && i_nrst |=> $stable(o_stack_pointer) && $stable(o_idx_hi)
        && $stable(o_busy) && $stable(o_ea)) else $error("state moved while disabled");
endmodule

bind crf_regfile crf_regfile_sva chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_acc(o_acc), .o_idx_hi(o_idx_hi), .o_idx_lo(o_idx_lo), .o_stack_pointer(o_stack_pointer),
    .o_x_carry(o_x_carry), .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_mem(o_mem), .o_busy(o_busy));

/* verification/crf_regfile_tb.sv */
// Self-checking bench for the CPU core register file.
// Assumes the design's command contract; the bench drives every input.
`timescale 1ns/10ps
module crf_regfile_tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic i_cmd_valid = 1'b0;
    crf_pkg::crf_cmd_t i_cmd = '0;
    logic [7:0] o_acc, o_idx_hi, o_idx_lo;
    logic [15:0] o_stack_pointer, o_ea;
    logic o_x_carry, o_ea_valid, o_busy;
    crf_pkg::crf_mem_t o_mem;
    // Reference copies of the registers
    logic [7:0] m_a, m_x, m_h;
    logic [15:0] m_sp;
    logic [15:0] seed = 16'h5351;
    logic [7:0] imms [4] = '{8'h80, 8'h7F, 8'hFF, 8'h01};
    int errors = 0;
    int checks_done = 0;
    // Pulses seen one step after the taking edge
    logic ea_seen;
    crf_pkg::crf_mem_t mem_seen;

    // ****************************************
    // Clock, design and helpers
    // ****************************************
    always #12.5 i_clk = ~i_clk;

    crf_regfile dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .o_acc(o_acc), .o_idx_hi(o_idx_hi), .o_idx_lo(o_idx_lo), .o_stack_pointer(o_stack_pointer),
        .o_x_carry(o_x_carry), .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_mem(o_mem), .o_busy(o_busy));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [15:0] sx(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    // Expected carry: shifts and rotates give the bit that falls off
    function automatic logic ucy(input crf_pkg::crf_uop_t op, input logic [7:0] d, input logic c);
        case (op)
            crf_pkg::UOP_CLR: return 1'b0;
            crf_pkg::UOP_COM: return 1'b1;
            crf_pkg::UOP_NEG: return d != 8'h00;
            crf_pkg::UOP_LSL, crf_pkg::UOP_ROL: return d[7];
            crf_pkg::UOP_LSR, crf_pkg::UOP_ASR, crf_pkg::UOP_ROR: return d[0];
            default: return c;
        endcase
    endfunction

    // Expected unary result
    function automatic logic [7:0] uop(input crf_pkg::crf_uop_t op, input logic [7:0] d, input logic c);
        case (op)
            crf_pkg::UOP_CLR: return 8'h00;
            crf_pkg::UOP_INC: return d + 8'h01;
            crf_pkg::UOP_DEC: return d - 8'h01;
            crf_pkg::UOP_COM: return ~d;
            crf_pkg::UOP_NEG: return 8'h00 - d;
            crf_pkg::UOP_LSL: return {d[6:0], 1'b0};
            crf_pkg::UOP_LSR: return {1'b0, d[7:1]};
            crf_pkg::UOP_ASR: return {d[7], d[7:1]};
            crf_pkg::UOP_ROL: return {d[6:0], c};
            default: return {c, d[7:1]};
        endcase
    endfunction

    // Address uses register values from before the command
    function automatic logic [15:0] ea_exp(input crf_pkg::crf_cmd_t c);
        case (c.amode)
            crf_pkg::AM_DIRECT: return {8'h00, c.addr_ofs[7:0]};
            crf_pkg::AM_EXTENDED: return c.addr_ofs;
            crf_pkg::AM_IDX_HX: return {m_h, m_x} + c.addr_ofs;
            crf_pkg::AM_IDX_X: return {8'h00, m_x} + c.addr_ofs;
            crf_pkg::AM_IDX_SP: return m_sp + c.addr_ofs;
            default: return c.pc + sx(c.addr_ofs[7:0]);
        endcase
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_regs();
        chk("acc", 16'(m_a), 16'(o_acc));
        chk("idx_lo", 16'(m_x), 16'(o_idx_lo));
        chk("idx_hi", 16'(m_h), 16'(o_idx_hi));
        chk("stack_pointer", m_sp, o_stack_pointer);
    endtask

    // One command, then wait until the mirrors show it
    task automatic run(input crf_pkg::crf_cmd_t c);
        @(posedge i_clk);
        i_cmd <= c;
        i_cmd_valid <= 1'b1;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        #1;
        ea_seen = o_ea_valid;
        mem_seen = o_mem;
        @(posedge i_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        m_h = 8'h00;
        m_sp = 16'h00FF;
        @(posedge i_clk);
        #1;
    endtask

    // Stacking; an accumulator write offered while busy must be ignored
    task automatic stack(input crf_pkg::crf_cmd_t c, input int n);
        logic [7:0] b [5];
        int k;
        b = '{c.pc[7:0], c.pc[15:8], m_x, m_a, c.ccr};
        k = 0;
        @(posedge i_clk);
        i_cmd <= c;
        i_cmd_valid <= 1'b1;
        @(posedge i_clk);
        i_cmd.acc_we <= 1'b1;
        i_cmd.acc_wdata <= ~m_a;
        i_cmd.stk <= crf_pkg::STK_NONE;
        for (int t = 0; t < 12 && k < n; t++) begin
            @(posedge i_clk);
            i_cmd_valid <= 1'b0;
            #1;
            if (o_mem.we === 1'b1) begin
                chk("stack addr", m_sp - 16'(k), o_mem.addr);
                chk("stack data", 16'(b[k]), 16'(o_mem.wdata));
                chk("busy", 16'(k != n - 1), 16'(o_busy));
                k++;
            end
        end
        chk("stack count", 16'(n), 16'(k));
        m_sp = m_sp - 16'(n);
        if (k < n) final_report();
        @(posedge i_clk);
        #1;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        crf_pkg::crf_cmd_t c;
        logic cy;
        do_reset();
        chk("sp reset", 16'h00FF, o_stack_pointer);
        chk("hi reset", 16'h0000, 16'(o_idx_hi));
        // Random loads of accumulator, low index and stack pointer together; high index only when a random bit is set
        repeat (40) begin
            c = '0;
            seed = lfsr(seed);
            c.acc_we = 1'b1;
            c.acc_wdata = seed[15:8];
            c.x_we = 1'b1;
            c.x_wdata = seed[7:0];
            seed = lfsr(seed);
            c.h_we = seed[0];
            c.h_wdata = seed[11:4];
            c.sp_op = crf_pkg::SPOP_LOAD;
            c.sp_wdata = seed;
            m_a = c.acc_wdata;
            m_x = c.x_wdata;
            m_h = c.h_we ? c.h_wdata : m_h;
            m_sp = seed;
            run(c);
            chk_regs();
            chk("ea_valid idle", 16'h0000, 16'(ea_seen));
            chk("mem idle", 16'h0000, 16'({mem_seen.we, mem_seen.re}));
        end
        // Every unary operation, with a competing plain write
        for (int i = 0; i < 10; i++) begin
            c = '0;
            seed = lfsr(seed);
            c.x_op_en = 1'b1;
            c.x_op = crf_pkg::crf_uop_t'(i);
            c.carry_in = seed[3];
            c.x_we = 1'b1;
            c.x_wdata = seed[15:8];
            cy = ucy(c.x_op, m_x, c.carry_in);
            m_x = uop(c.x_op, m_x, c.carry_in);
            run(c);
            chk_regs();
            chk("x_carry", 16'(cy), 16'(o_x_carry));
        end
        // Signed adjust at the extremes, then low reset
        for (int j = 0; j < 4; j++) begin
            c = '0;
            c.sp_op = crf_pkg::SPOP_ADJUST;
            c.sp_imm = imms[j];
            m_sp = m_sp + sx(imms[j]);
            run(c);
            chk_regs();
        end
        c = '0;
        c.sp_op = crf_pkg::SPOP_LOW_RESET;
        m_sp[7:0] = 8'hFF;
        run(c);
        chk_regs();
        // Every address mode with random offsets
        for (int m = 1; m < 7; m++) begin
            c = '0;
            seed = lfsr(seed);
            c.amode = crf_pkg::crf_amode_t'(m);
            c.addr_ofs = seed;
            c.pc = ~seed;
            run(c);
            chk("ea", ea_exp(c), o_ea);
            chk("ea_valid", 16'h0001, 16'(ea_seen));
        end
        // One push of a random byte, then the pull that frees it
        seed = lfsr(seed);
        c = '0;
        c.sp_op = crf_pkg::SPOP_PUSH;
        c.sp_wdata = seed;
        run(c);
        chk("push addr", m_sp, mem_seen.addr);
        chk("push we re data", 16'({2'b10, seed[7:0]}), 16'({mem_seen.we, mem_seen.re, mem_seen.wdata}));
        m_sp = m_sp - 16'h0001;
        chk_regs();
        c.sp_op = crf_pkg::SPOP_PULL;
        run(c);
        m_sp = m_sp + 16'h0001;
        chk("pull addr", m_sp, mem_seen.addr);
        chk("pull we re", 16'h0001, 16'({mem_seen.we, mem_seen.re}));
        chk_regs();
        c = '0;
        c.stk = crf_pkg::STK_CALL;
        c.pc = seed;
        stack(c, 2);
        c.stk = crf_pkg::STK_IRQ;
        c.ccr = seed[7:0];
        stack(c, 5);
        chk_regs();
        // Disabled clock must ignore a valid command
        @(posedge i_clk);
        c = '0;
        c.acc_we = 1'b1;
        c.acc_wdata = ~m_a;
        i_ce <= 1'b0;
        i_cmd <= c;
        i_cmd_valid <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        i_ce <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        chk_regs();
        do_reset();
        chk_regs();
        final_report();
    end
endmodule
